// File: rtl/ixadd_defines.svh
`ifndef IXADD_DEFINES_SVH
`define IXADD_DEFINES_SVH

// Datapath shape: positions 3 (bit 14) through 17 (bit 0)
`define IXADD_WIDTH 15
`define IXADD_GRP_SIZE 5
`define IXADD_NUM_GRP 3

// Reset and forced operand values
`define IXADD_LATCH_RST 15'h0000
`define IXADD_ONES 15'h7FFF
`define IXADD_HOT_LOW 15'h0001
`define IXADD_CARRY_RST 1'h0

// Source and destination counts
`define IXADD_NSRC_A 6
`define IXADD_NSRC_B 4
`define IXADD_NDEST 8

`endif

// File: rtl/ixadd_pkg.sv
`include "ixadd_defines.svh"

package ixadd_pkg;

	// Input A gates, at most one honoured per cycle
	typedef struct packed {
		logic srAddr;
		logic srDecr;
		logic ibrAddr;
		logic pc;
		logic ar;
		logic xr;
	} ixadd_srcA_t;

	// Input B gates, at most one honoured per cycle
	typedef struct packed {
		logic xrComp;
		logic xrTrue;
		logic onesAll;
		logic hotLow;
	} ixadd_srcB_t;

	// Receivers of the latch output
	typedef struct packed {
		logic xr;
		logic pc;
		logic ar;
		logic instruction_backup_register;
		logic srHigh;
		logic srLow;
		logic shiftCnt;
		logic memory_address_register;
	} ixadd_dest_t;

endpackage

// File: rtl/ixadd_lookahead.sv
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// (RL1) Upper groups drive any-generate and generate-or-propagate; carry needs both.
// (RL2) Any-generate is high when some position has both operands one.
// (RL3) Generate-or-propagate: all propagate, or non-lowest generate propagated above.
// (RL4) Group carry: lower group generates, or propagates a carry from below.
// (RL5) Every group carry formed directly from lower group outputs, no ripple.
// (RL6) Lowest group carries on internal generate, or input carry with all propagate.
// (RL7) Top-end carry out computed by lookahead from group outputs.
// (RL8) Address modify: instruction address on A, complemented index on B.
// (RL9) Increment: counter, address or backup register on A, one at position 17.
// (RL10) Ones in all B positions decrement; one at 17 alone increments.
// (RL11) Data path output routed to storage register halves or shift counter.
// (RL12) During overlap the output supplies a second address to the address switch.
// (RL13) Tag zero forces all B ones plus carry, leaving address unchanged.
// (RL14) Latch captures sum every clock; destination loads from latch next period.
// (RL15) Four flops remember which register receives the latch output.
// (RL16) At most one source enabled on A and on B per cycle.
// (RL17) Propagate is A or B; generate is A and B per position.
// (RL18) Exclusive-or formed per position, used only inside it.
// (RL19) Fifteen positions 3 to 17, three groups of five.
// (RL20) Second and third groups use the two-output group structure.
// (RL21) Sum is operand exclusive-or with the carry into the position.
// (RL22) Whole add is combinational, settling within one clock period.
module ixadd_lookahead
	import ixadd_pkg::*;
#(
	// Shape of the datapath
	parameter int WIDTH = `IXADD_WIDTH,
	parameter int GRP_SIZE = `IXADD_GRP_SIZE,
	parameter int NUM_GRP = `IXADD_NUM_GRP
) (
	input wire logic clk,
	input wire logic rst_b,
	// Gates and controls
	input wire ixadd_srcA_t gateA,
	input wire ixadd_srcB_t gateB,
	input wire ixadd_dest_t destReq,
	input wire logic carryInLow,
	input wire logic tagZero,
	// Operand sources
	input wire logic [WIDTH-1:0] srAddrIn,
	input wire logic [WIDTH-1:0] srDecrIn,
	input wire logic [WIDTH-1:0] ibrAddrIn,
	input wire logic [WIDTH-1:0] pcIn,
	input wire logic [WIDTH-1:0] arIn,
	input wire logic [WIDTH-1:0] xrIn,
	// Latched results
	output logic [WIDTH-1:0] latchOut,
	output ixadd_dest_t destLoad,
	output logic carryOut
);

	// Gate requests, raw and cut to one each
	logic [`IXADD_NSRC_A-1:0] rawA;
	logic [`IXADD_NSRC_A-1:0] oneA;
	logic [`IXADD_NSRC_B-1:0] rawB;
	logic [`IXADD_NSRC_B-1:0] oneB;

	// Honoured gates
	ixadd_srcA_t selA;
	ixadd_srcB_t selB;

	// Gated operands and the carry into position 17
	logic [WIDTH-1:0] opA;
	logic [WIDTH-1:0] opBGate;
	logic [WIDTH-1:0] opB;
	logic carryIn;

	// Per-position terms
	logic [WIDTH-1:0] prop;
	logic [WIDTH-1:0] gen;
	logic [WIDTH-1:0] xorAB;
	logic [WIDTH-1:0] bitCarry;
	logic [WIDTH-1:0] sum;

	// Per-group lookahead outputs
	logic [NUM_GRP-1:0] grpAny;
	logic [NUM_GRP-1:0] grpGop;
	logic [NUM_GRP-1:0] grpFull;
	logic [NUM_GRP-1:0] grpAllP;
	logic [NUM_GRP-1:0] grpGen;
	logic [NUM_GRP-1:0] grpPass;
	logic [NUM_GRP:0] grpCarry;
	logic carryLook;

	// Latch and receiver delay flops
	logic [WIDTH-1:0] latch_q;
	logic [3:0] regDest_q;
	logic [3:0] pathDest_q;
	logic carry_q;

	// Generate from positions first..top, each passed through all positions above
	// Built from position terms only, no carry enters
	function automatic logic genUp(input logic [GRP_SIZE-1:0] g, input logic [GRP_SIZE-1:0] p,
		input int first);
		logic acc;
		logic chain;

		acc = 1'b0;
		chain = 1'b1;
		for (int k = GRP_SIZE - 1; k >= first; k--) begin
			acc = acc | (g[k] & chain);
			chain = chain & p[k];
		end
		return acc;
	endfunction

	// Carry into local position j, expanded from position inputs and the carry into the group
	// No ripple: each position sees all lower terms at once
	function automatic logic localCarry(input logic [GRP_SIZE-1:0] g, input logic [GRP_SIZE-1:0] p,
		input logic cin, input int j);
		logic acc;
		logic chain;

		acc = 1'b0;
		chain = 1'b1;
		for (int k = j - 1; k >= 0; k--) begin
			acc = acc | (g[k] & chain);
			chain = chain & p[k];
		end
		return acc | (chain & cin);
	endfunction

	// Keep only the lowest requested gate on input A
	always_comb begin
		rawA = gateA;
		oneA = rawA & (~rawA + `IXADD_NSRC_A'(1)); // RL16
		selA = oneA;
	end

	// Same for input B
	always_comb begin
		rawB = gateB;
		oneB = rawB & (~rawB + `IXADD_NSRC_B'(1)); // RL16
		selB = oneB;
	end

	// Operand A from the honoured source
	always_comb begin
		// No gate leaves the operand at zero
		opA = '0;
		if (selA.srAddr) begin
			opA = srAddrIn; // RL8
		end
		if (selA.srDecr) begin
			opA = srDecrIn;
		end
		if (selA.ibrAddr) begin
			opA = ibrAddrIn; // RL8
		end
		if (selA.pc) begin
			opA = pcIn; // RL9
		end
		if (selA.ar) begin
			opA = arIn; // RL9
		end
		if (selA.xr) begin
			opA = xrIn;
		end
	end

	// Operand B from the gates alone
	always_comb begin
		opBGate = '0;
		if (selB.xrComp) begin
			opBGate = ~xrIn; // RL8
		end
		if (selB.xrTrue) begin
			opBGate = xrIn;
		end
		if (selB.onesAll) begin
			opBGate = `IXADD_ONES; // RL10
		end
		if (selB.hotLow) begin
			opBGate = `IXADD_HOT_LOW; // RL9
		end
	end

	// Tag zero overrides the gates: all ones and a carry
	always_comb begin
		opB = opBGate;
		carryIn = carryInLow;
		if (tagZero) begin
			opB = `IXADD_ONES; // RL13
			carryIn = 1'h1; // RL13
		end
	end

	// Per-position propagate and generate
	genvar bi;
	generate
		for (bi = 0; bi < WIDTH; bi++) begin : g_bit
			assign prop[bi] = opA[bi] | opB[bi]; // RL17
			assign gen[bi] = opA[bi] & opB[bi]; // RL17
		end
	endgenerate

	// Local exclusive-or, never leaves the position
	genvar xi;
	generate
		for (xi = 0; xi < WIDTH; xi++) begin : g_xor
			assign xorAB[xi] = opA[xi] ^ opB[xi]; // RL18
		end
	endgenerate

	// Sum from local exclusive-or and the carry into the position
	genvar si;
	generate
		for (si = 0; si < WIDTH; si++) begin : g_sum
			assign sum[si] = xorAB[si] ^ bitCarry[si]; // RL21
		end
	endgenerate

	// Group outputs
	genvar gi;
	generate
		for (gi = 0; gi < NUM_GRP; gi++) begin : g_grp
			logic [GRP_SIZE-1:0] gp;
			logic [GRP_SIZE-1:0] gg;
			assign gp = prop[gi*GRP_SIZE +: GRP_SIZE]; // RL19
			assign gg = gen[gi*GRP_SIZE +: GRP_SIZE];
			assign grpAny[gi] = |gg; // RL2
			assign grpAllP[gi] = &gp;
			assign grpGop[gi] = grpAllP[gi] | genUp(gg, gp, 1); // RL3 RL20
			assign grpFull[gi] = genUp(gg, gp, 0);
		end
	endgenerate

	// In-group carries from position terms and the group carry
	genvar hi;
	genvar ji;
	generate
		for (hi = 0; hi < NUM_GRP; hi++) begin : g_cin
			for (ji = 0; ji < GRP_SIZE; ji++) begin : g_pos
				assign bitCarry[hi*GRP_SIZE + ji] = localCarry(gen[hi*GRP_SIZE +: GRP_SIZE],
					prop[hi*GRP_SIZE +: GRP_SIZE], grpCarry[hi], ji); // RL22
			end
		end
	endgenerate

	// Group generate and pass, lowest group from its own positions
	genvar ci;
	generate
		for (ci = 0; ci < NUM_GRP; ci++) begin : g_term
			if (ci == 0) begin : g_low
				assign grpGen[ci] = grpFull[ci]; // RL6
				assign grpPass[ci] = grpAllP[ci]; // RL6
			end else begin : g_up
				assign grpGen[ci] = grpAny[ci] & grpGop[ci]; // RL1
				assign grpPass[ci] = grpGop[ci]; // RL4
			end
		end
	endgenerate

	// Group carries, each formed from all lower group outputs at once
	always_comb begin
		logic acc;
		logic chain;
		acc = 1'b0;
		chain = 1'b1;
		grpCarry = '0;
		// Lowest group sees the input carry
		grpCarry[0] = carryIn;
		grpCarry[1] = grpFull[0] | (grpAllP[0] & carryIn); // RL6
		// Upper groups: generate, or pass what arrives
		for (int k = 2; k <= NUM_GRP; k++) begin
			acc = 1'b0;
			chain = 1'b1;
			for (int j = k - 1; j >= 1; j--) begin
				acc = acc | (grpAny[j] & grpGop[j] & chain); // RL1 RL4
				chain = chain & grpGop[j];
			end
			grpCarry[k] = acc | (chain & grpCarry[1]); // RL4 RL5 RL7
		end
	end

	// Top-end carry straight from group terms, not from group carries
	always_comb begin
		logic outAcc;
		logic outChain;
		outAcc = 1'h0;
		outChain = 1'h1;
		for (int k = NUM_GRP - 1; k >= 0; k--) begin
			outAcc = outAcc | (grpGen[k] & outChain); // RL7
			outChain = outChain & grpPass[k];
		end
		carryLook = outAcc | (outChain & carryIn); // RL7
	end

	// Free-running latch
	// The receiving registers are plain flops; this is their one delay
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			latch_q <= `IXADD_LATCH_RST;
		end else begin
			latch_q <= sum; // RL14
		end
	end

	// Four flops remember the register receiver after the gate drops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			regDest_q <= '0;
		end else begin
			regDest_q[3] <= destReq.xr; // RL15
			regDest_q[2] <= destReq.pc; // RL15
			regDest_q[1] <= destReq.ar; // RL15
			regDest_q[0] <= destReq.instruction_backup_register; // RL15
		end
	end

	// Data path and overlap receivers ride the same delay
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pathDest_q <= '0;
		end else begin
			pathDest_q[3] <= destReq.srHigh; // RL11
			pathDest_q[2] <= destReq.srLow; // RL11
			pathDest_q[1] <= destReq.shiftCnt; // RL11
			pathDest_q[0] <= destReq.memory_address_register; // RL12
		end
	end

	// Carry out held beside the latch
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			carry_q <= `IXADD_CARRY_RST;
		end else begin
			carry_q <= carryLook; // RL7
		end
	end

	// Outputs straight from the flops
	assign latchOut = latch_q; // RL14
	assign destLoad = ixadd_dest_t'({regDest_q, pathDest_q}); // RL15
	assign carryOut = carry_q;

endmodule

`default_nettype wire

// File: verification/ixadd_lookahead_props.sv
`timescale 1ns/100ps
`default_nettype none
module ixadd_lookahead_chk
	import ixadd_pkg::*;
#(
	parameter int WIDTH = 15
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire ixadd_srcA_t gateA,
	input wire ixadd_srcB_t gateB,
	input wire ixadd_dest_t destReq,
	input wire logic carryInLow,
	input wire logic tagZero,
	input wire logic [WIDTH-1:0] srAddrIn,
	input wire logic [WIDTH-1:0] srDecrIn,
	input wire logic [WIDTH-1:0] ibrAddrIn,
	input wire logic [WIDTH-1:0] pcIn,
	input wire logic [WIDTH-1:0] arIn,
	input wire logic [WIDTH-1:0] xrIn,
	input wire logic [WIDTH-1:0] latchOut,
	input wire ixadd_dest_t destLoad,
	input wire logic carryOut
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire q = !tagZero && !carryInLow;
	chk_dest_delay: assert property (1 |=> destLoad == $past(destReq)) else $error("dest delay");
	chk_incr_pc: assert property (q && gateA == 6'h04 && gateB == 4'h1 |=>
		{carryOut, latchOut} == $past(pcIn) + 16'h0001) else $error("increment");
	chk_decr_ar: assert property (q && gateA == 6'h02 && gateB == 4'h2 |=>
		{carryOut, latchOut} == $past(arIn) + 16'h7FFF) else $error("decrement");
	chk_addr_modify: assert property (!tagZero && gateA == 6'h20 && gateB == 4'h8 |=> {carryOut, latchOut} ==
		$past(srAddrIn) + {1'b0, ~$past(xrIn)} + $past(carryInLow)) else $error("modify");
	chk_tag_pass: assert property (tagZero && gateA == 6'h08 |=> latchOut == $past(ibrAddrIn) && carryOut)
		else $error("tag zero");
	chk_data_path: assert property (q && gateA == 6'h10 && gateB == 4'h0 |=>
		latchOut == $past(srDecrIn) && !carryOut) else $error("pass");
	chk_group_carry: assert property (!tagZero && gateA == 6'h01 && gateB == 4'h4 |=>
		{carryOut, latchOut} == {$past(xrIn), $past(carryInLow)}) else $error("double");
	chk_low_carry: assert property (!tagZero && gateA == 6'h00 && gateB == 4'h0 |=>
		latchOut == {14'h0000, $past(carryInLow)} && !carryOut) else $error("idle");
endmodule
bind ixadd_lookahead ixadd_lookahead_chk #(.WIDTH(WIDTH)) ixadd_lookahead_chk_inst (.clk, .rst_b, .gateA, .gateB,
	.destReq, .carryInLow, .tagZero, .srAddrIn, .srDecrIn, .ibrAddrIn, .pcIn, .arIn, .xrIn, .latchOut, .destLoad,
	.carryOut);
`default_nettype wire

// File: verification/ixadd_regs.sv
`timescale 1ns/100ps
`default_nettype none
module ixadd_regs
	import ixadd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [14:0] latchOut,
	input wire ixadd_dest_t destLoad,
	output logic [14:0] xr_q,
	output logic [14:0] pc_q,
	output logic [14:0] ar_q,
	output logic [14:0] ibr_q
);
	// Receivers take the latch one period after capture
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{xr_q, pc_q, ar_q, ibr_q} <= '0;
		end else begin
			if (destLoad.xr) xr_q <= latchOut;
			if (destLoad.pc) pc_q <= latchOut;
			if (destLoad.ar) ar_q <= latchOut;
			if (destLoad.instruction_backup_register) ibr_q <= latchOut;
		end
	end
endmodule
`default_nettype wire

// File: verification/ixadd_lookahead_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ixadd_lookahead_tb_top;
	import ixadd_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	ixadd_srcA_t gA = '0;
	ixadd_srcB_t gB = '0;
	ixadd_dest_t dR = '0;
	logic cin = 1'b0;
	logic tz = 1'b0;
	logic [14:0] srA = 15'h0000;
	logic [14:0] srD = 15'h0000;
	logic [14:0] latchOut, xr_q, pc_q, ar_q, ibr_q, r;
	ixadd_dest_t destLoad;
	logic cOut;
	logic [31:0] seed = 32'h46677C61;
	int n_mismatch = 0;
	int n_compared = 0;
	always #25 clk = ~clk;
	ixadd_lookahead ixadd_lookahead_inst (.clk, .rst_b, .gateA(gA), .gateB(gB), .destReq(dR), .carryInLow(cin),
		.tagZero(tz), .srAddrIn(srA), .srDecrIn(srD), .ibrAddrIn(ibr_q), .pcIn(pc_q), .arIn(ar_q), .xrIn(xr_q),
		.latchOut, .destLoad, .carryOut(cOut));
	ixadd_regs ixadd_regs_inst (.clk, .rst_b, .latchOut, .destLoad, .xr_q, .pc_q, .ar_q, .ibr_q);
	function automatic logic [14:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[14:0];
	endfunction
	function automatic logic [15:0] expv();
		logic [14:0] a;
		logic [14:0] b;
		a = gA[0] ? xr_q : gA[1] ? ar_q : gA[2] ? pc_q : gA[3] ? ibr_q : gA[4] ? srD : gA[5] ? srA : 15'h0000;
		b = tz ? 15'h7FFF : gB[0] ? 15'h0001 : gB[1] ? 15'h7FFF : gB[2] ? xr_q : gB[3] ? ~xr_q : 15'h0000;
		return {1'b0, a} + {1'b0, b} + {15'h0000, cin | tz};
	endfunction
	task automatic check(input logic [23:0] seen, input logic [23:0] want, input string what);
		n_compared++;
		if (seen !== want) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic step(input logic [5:0] a, input logic [3:0] b, input logic [7:0] d, input logic c, input logic t);
		logic [23:0] e;
		gA = a;
		gB = b;
		dR = d;
		cin = c;
		tz = t;
		srA = rnd();
		srD = rnd();
		#1 e = {d, expv()};
		@(posedge clk);
		#2 check({destLoad, cOut, latchOut}, e, "outputs");
		$display("step %0d done", n_compared);
	endtask
	task automatic conclude();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// About twenty-five times the expected run
	initial begin
		#100000 n_mismatch++;
		conclude();
	end
	initial begin
		repeat (10) @(posedge clk);
		#2 rst_b = 1'b1;
		step(6'h02, 4'h2, 8'h20, 1'b0, 1'b0);
		step(6'h00, 4'h0, 8'h00, 1'b1, 1'b0);
		step(6'h02, 4'h1, 8'h20, 1'b0, 1'b0);
		for (int i = 0; i < 4; i++) step(6'h10, 4'h0, 8'h80 >> i, 1'b0, 1'b0);
		step(6'h04, 4'h1, 8'h40, 1'b0, 1'b0);
		step(6'h20, 4'h8, 8'h01, 1'b1, 1'b0);
		step(6'h08, 4'h4, 8'h02, 1'b0, 1'b1);
		step(6'h01, 4'h4, 8'h04, 1'b1, 1'b0);
		repeat (60) begin
			r = rnd();
			step(r[5:0], r[9:6], r[14:7], r[10], r[11] & r[12]);
		end
		conclude();
	end
endmodule
`default_nettype wire
